/* gcpm_pin_mux.sv */
// Operation
// [RULE1] Host-select strap low picks SD-style bus, high picks serial interface
// [RULE2] Board keeps host-select strap pin for bus selection only
// [RULE3] Pin one floats at reset, then direction set by software
// [RULE4] Pin one has software weak pull-up or pull-down, independent of direction
// [RULE5] Pin one can drive the out-of-band host interrupt
// [RULE6] Pin one is general by default, remappable to restricted-channel input
// [RULE7] Pins three to five float at reset, each with own direction and pull
// [RULE8] Only pins 1, 3, 4, 5 are general pins, four in total
// [RULE9] Slew limiting enabled after reset, software may disable it
// [RULE10] Pin three in coexistence mode drives transmit grant, remappable to general
// [RULE11] Peer drives pin four with priority and direction status
// [RULE12] Peer drives pin five to show it is active
// [RULE13] Wireless reset active low, pulled down when undriven
// [RULE14] Reset pin pull-down released within 1.5 ms after release, software may re-enable
// [RULE15] Power manager powered down while wireless reset is low
// [RULE16] Supply-share request puts buck in external mode, rest stays powered
// [RULE17] Pwm force request forces buck into pulse-width modulation
// [RULE18] Host-select strap latched at reset release, later changes ignored
`timescale 1ns/1ps
module gcpm_pin_mux
  import gcpm_pkg::*;
#(
  parameter int pd_release_cycles = gcpm_pd_release_cycles
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic host_select_in,
  output logic host_bus_spi,
  input wire logic [3:0] gpio_in,
  output logic [3:0] gpio_out,
  output logic [3:0] gpio_oe,
  output logic [3:0] gpio_pull_en,
  output logic [3:0] gpio_pull_up,
  output logic slew_limit_en,
  input wire logic coex_tx_grant_src,
  input wire logic host_irq_src,
  output logic coex_restricted_channel_in,
  output logic coex_priority_direction_in,
  output logic coex_peer_active_in,
  input wire logic wireless_reset_n,
  output logic wireless_reset_pd_en,
  output logic power_manager_on,
  input wire logic supply_share_request,
  input wire logic buck_pwm_force_request,
  output logic core_buck_external,
  output logic core_buck_pwm
);
  // ----------------------------------------
  // Pin index 0..3 maps to general pins 1, 3, 4, 5 [RULE8]
  // ----------------------------------------
  logic [3:0] dir;
  logic [3:0] dout;
  logic [3:0] pull_en;
  logic [3:0] pull_up;
  logic [4:0] mode;
  logic [3:0] misc;
  logic strap;
  logic pd_auto;
  logic [23:0] pd_count;
  gcpm_state_type state;
  gcpm_state_type next_state;
  logic [31:0] next_prdata;

  wire active = wireless_reset_n && state == gcpm_st_run;
  wire wr = psel && penable && pwrite;
  wire rd_access = psel && !pwrite;
  wire mapped = paddr[11:5] == 7'h00 && paddr[1:0] == 2'b00;
  wire ro_hit = paddr == gcpm_status_off || paddr == gcpm_pins_off;

  // Coexistence mux: pin three grant out, four and five peer inputs
  wire grant_mode = mode[gcpm_mode_coex_grant_bit];
  wire irq_mode = mode[gcpm_mode_irq_bit];
  wire freq_mode = mode[gcpm_mode_coex_freq_bit];
  wire status_mode = mode[gcpm_mode_coex_status_bit];
  wire act_mode = mode[gcpm_mode_coex_active_bit];
  wire grant_val = misc[gcpm_misc_grant_bit] | coex_tx_grant_src;
  wire irq_val = misc[gcpm_misc_irq_bit] | host_irq_src;

  // ----------------------------------------
  // Pad drive
  // ----------------------------------------
  // Everything floats until the device is out of reset; pulls are released as well
  always_comb
  begin
    gpio_oe = 4'h0;
    gpio_out = 4'h0;
    if (active)
    begin
      gpio_oe = dir; // [RULE3] [RULE7]
      gpio_out = dout;
      if (irq_mode)
      begin
        gpio_oe[0] = 1'b1; // [RULE5]
        gpio_out[0] = irq_val;
      end
      if (freq_mode)
      begin
        gpio_oe[0] = 1'b0; // [RULE6]
      end
      if (grant_mode)
      begin
        gpio_oe[1] = 1'b1; // [RULE10]
        gpio_out[1] = grant_val;
      end
      if (status_mode)
      begin
        gpio_oe[2] = 1'b0; // [RULE11]
      end
      if (act_mode)
      begin
        gpio_oe[3] = 1'b0; // [RULE12]
      end
    end
  end

  assign gpio_pull_en = active ? pull_en : 4'h0; // [RULE4] [RULE7]
  assign gpio_pull_up = active ? pull_up : 4'h0;
  assign slew_limit_en = misc[gcpm_misc_slew_bit]; // [RULE9]
  assign coex_restricted_channel_in = active && freq_mode && gpio_in[0];
  assign coex_priority_direction_in = active && status_mode && gpio_in[2];
  assign coex_peer_active_in = active && act_mode && gpio_in[3];
  assign host_bus_spi = strap; // [RULE1]
  assign power_manager_on = wireless_reset_n; // [RULE15]
  assign core_buck_external = power_manager_on && supply_share_request; // [RULE16]
  assign core_buck_pwm = power_manager_on && buck_pwm_force_request; // [RULE17]
  // Held low pin pulls down at once, not one clock later when pd_auto reloads
  assign wireless_reset_pd_en = !wireless_reset_n || pd_auto ||
                                misc[gcpm_misc_rst_pd_bit]; // [RULE13] [RULE14]

  // ----------------------------------------
  // Reset sequencing
  // ----------------------------------------
  always_comb
  begin
    next_state = state;
    case (state)
      gcpm_st_reset: next_state = wireless_reset_n ? gcpm_st_wait : gcpm_st_reset;
      gcpm_st_wait: next_state = gcpm_st_run;
      gcpm_st_run: next_state = wireless_reset_n ? gcpm_st_run : gcpm_st_reset;
      default: next_state = gcpm_st_reset;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= gcpm_st_reset;
      strap <= 1'b0;
    end
    else
    begin
      state <= next_state;
      // Sampled while held in reset, frozen once running
      if (state == gcpm_st_reset)
      begin
        strap <= host_select_in; // [RULE18]
      end
    end
  end

  // Counter restarts on every wireless reset so the release is measured from the rising edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pd_auto <= 1'b1;
      pd_count <= 24'h00_0000;
    end
    else if (!wireless_reset_n)
    begin
      pd_auto <= 1'b1;
      pd_count <= 24'h00_0000;
    end
    else if (pd_auto)
    begin
      pd_count <= pd_count + 24'h00_0001;
      if (pd_count >= 24'(pd_release_cycles - 1))
      begin
        pd_auto <= 1'b0; // [RULE14]
      end
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // Software state is cleared only on bus reset, so settings survive a wireless reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dir <= gcpm_gpio_rst;
      dout <= gcpm_gpio_rst;
      pull_en <= gcpm_gpio_rst;
      pull_up <= gcpm_gpio_rst;
      mode <= gcpm_mode_rst;
      misc <= gcpm_misc_rst;
    end
    else if (wr)
    begin
      case (paddr)
        gcpm_dir_off: dir <= pwdata[3:0];
        gcpm_out_off: dout <= pwdata[3:0];
        gcpm_pull_en_off: pull_en <= pwdata[3:0];
        gcpm_pull_up_off: pull_up <= pwdata[3:0];
        gcpm_mode_off: mode <= pwdata[4:0];
        gcpm_misc_off: misc <= pwdata[3:0];
        default: dir <= dir;
      endcase
    end
  end

  always_comb
  begin
    next_prdata = 32'h0000_0000;
    case (paddr)
      gcpm_dir_off: next_prdata = {28'h000_0000, dir};
      gcpm_out_off: next_prdata = {28'h000_0000, dout};
      gcpm_pull_en_off: next_prdata = {28'h000_0000, pull_en};
      gcpm_pull_up_off: next_prdata = {28'h000_0000, pull_up};
      gcpm_mode_off: next_prdata = {27'h000_0000, mode};
      gcpm_misc_off: next_prdata = {28'h000_0000, misc};
      gcpm_status_off: next_prdata = {26'h000_0000, core_buck_pwm, core_buck_external,
                                       wireless_reset_pd_en, power_manager_on, active, strap};
      gcpm_pins_off: next_prdata = {28'h000_0000, gpio_in};
      default: next_prdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
    end
    else if (psel && !penable && rd_access)
    begin
      prdata <= next_prdata;
    end
  end

  assign pready = 1'b1;
  assign pslverr = psel && penable && (!mapped || (pwrite && ro_hit));

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_float_in_reset;
    @(posedge pclk) disable iff (!presetn)
      !wireless_reset_n |-> gpio_oe == 4'h0 && gpio_pull_en == 4'h0;
  endproperty
  a_float_in_reset: assert property (p_float_in_reset) // [RULE3]
    else $error("pins driven during reset");

  property p_strap_frozen;
    @(posedge pclk) disable iff (!presetn)
      state == gcpm_st_run && $past(state) == gcpm_st_run |-> $stable(host_bus_spi);
  endproperty
  a_strap_frozen: assert property (p_strap_frozen) // [RULE18]
    else $error("strap changed while running");

  property p_grant_out;
    @(posedge pclk) disable iff (!presetn)
      active && grant_mode |-> gpio_oe[1] && gpio_out[1] == grant_val;
  endproperty
  a_grant_out: assert property (p_grant_out) // [RULE10]
    else $error("grant not driven");

  property p_peer_inputs;
    @(posedge pclk) disable iff (!presetn)
      (status_mode |-> !gpio_oe[2]) and (act_mode |-> !gpio_oe[3]);
  endproperty
  a_peer_inputs: assert property (p_peer_inputs) // [RULE11] [RULE12]
    else $error("peer pin driven");

  sequence s_release;
    !wireless_reset_n ##1 wireless_reset_n;
  endsequence
  property p_pd_release;
    @(posedge pclk) disable iff (!presetn)
      s_release |-> wireless_reset_pd_en ##1 (!wireless_reset_n || pd_count <= 24'(pd_release_cycles));
  endproperty
  a_pd_release: assert property (p_pd_release) // [RULE14]
    else $error("pull-down release timing");

  // Own count of cycles with the reset pin high, so the deadline check does not lean on pd_count
  logic [23:0] rel_count;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rel_count <= 24'h00_0000;
    end
    else
    begin
      rel_count <= !wireless_reset_n ? 24'h00_0000 :
                   (rel_count == 24'hFF_FFFF) ? rel_count : rel_count + 24'h00_0001;
    end
  end

  property p_pd_deadline;
    @(posedge pclk) disable iff (!presetn)
      wireless_reset_n && rel_count >= 24'(pd_release_cycles) |-> !pd_auto;
  endproperty
  a_pd_deadline: assert property (p_pd_deadline) // [RULE14]
    else $error("pull-down held too long");

  property p_pmu_off;
    @(posedge pclk) disable iff (!presetn)
      !wireless_reset_n |-> !power_manager_on && !core_buck_external && !core_buck_pwm;
  endproperty
  a_pmu_off: assert property (p_pmu_off) // [RULE15]
    else $error("power manager on in reset");

  property p_buck_ext;
    @(posedge pclk) disable iff (!presetn)
      wireless_reset_n && supply_share_request |-> core_buck_external && power_manager_on;
  endproperty
  a_buck_ext: assert property (p_buck_ext) // [RULE16]
    else $error("buck external mode missing");

  property p_buck_pwm;
    @(posedge pclk) disable iff (!presetn)
      wireless_reset_n && buck_pwm_force_request |-> core_buck_pwm;
  endproperty
  a_buck_pwm: assert property (p_buck_pwm) // [RULE17]
    else $error("buck pwm missing");

  property p_irq_out;
    @(posedge pclk) disable iff (!presetn)
      active && irq_mode && !freq_mode |-> gpio_oe[0] && gpio_out[0] == irq_val;
  endproperty
  a_irq_out: assert property (p_irq_out) // [RULE5]
    else $error("host irq not driven");
endmodule

/* gcpm_pkg.sv */
package gcpm_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [11:0] gcpm_dir_off = 12'h000;
  localparam logic [11:0] gcpm_out_off = 12'h004;
  localparam logic [11:0] gcpm_pull_en_off = 12'h008;
  localparam logic [11:0] gcpm_pull_up_off = 12'h00C;
  localparam logic [11:0] gcpm_mode_off = 12'h010;
  localparam logic [11:0] gcpm_misc_off = 12'h014;
  localparam logic [11:0] gcpm_status_off = 12'h018;
  localparam logic [11:0] gcpm_pins_off = 12'h01C;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int gcpm_mode_coex_freq_bit = 0;
  localparam int gcpm_mode_coex_grant_bit = 1;
  localparam int gcpm_mode_coex_status_bit = 2;
  localparam int gcpm_mode_coex_active_bit = 3;
  localparam int gcpm_mode_irq_bit = 4;
  localparam int gcpm_misc_slew_bit = 0;
  localparam int gcpm_misc_rst_pd_bit = 1;
  localparam int gcpm_misc_grant_bit = 2;
  localparam int gcpm_misc_irq_bit = 3;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [3:0] gcpm_gpio_rst = 4'h0;
  localparam logic [4:0] gcpm_mode_rst = 5'h0E;
  localparam logic [3:0] gcpm_misc_rst = 4'h1;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int gcpm_clk_khz = 25000;
  localparam int gcpm_pd_release_us = 1500;
  localparam int gcpm_pd_release_cycles = gcpm_pd_release_us * gcpm_clk_khz / 1000;
  typedef enum logic [1:0] {
    gcpm_st_reset = 2'b00,
    gcpm_st_wait = 2'b01,
    gcpm_st_run = 2'b11
  } gcpm_state_type;
endpackage

/* gcpm_peer_model.sv */
`timescale 1ns/1ps
module gcpm_peer_model
(
  input wire logic pclk,
  input wire logic strap,
  input wire logic peer_on,
  input wire logic [2:0] peer_lvl,
  input wire logic [3:0] gpio_out,
  input wire logic [3:0] gpio_oe,
  input wire logic [3:0] gpio_pull_en,
  input wire logic [3:0] gpio_pull_up,
  output logic host_select_in,
  output logic [3:0] gpio_in
);
  logic flip = 1'b0;
  logic [3:0] peer_oe;
  logic [3:0] peer_val;
  // Strap pin stays a pure bus select on this board
  assign host_select_in = strap;
  // Peer drives pin1 restricted channel, pin4 status, pin5 active
  assign peer_oe = {peer_on, peer_on, 1'b0, peer_on};
  assign peer_val = {peer_lvl[2], peer_lvl[1], 1'b0, peer_lvl[0]};
  always_ff @(posedge pclk)
    flip <= ~flip;
  // Floating pads toggle so a stale level never passes for a match
  always_comb
    for (int i = 0; i < 4; i++)
      gpio_in[i] = gpio_oe[i] ? gpio_out[i] : peer_oe[i] ? peer_val[i] :
                   gpio_pull_en[i] ? gpio_pull_up[i] : flip;
endmodule

/* gcpm_pin_mux_tb.sv */
`timescale 1ns/1ps
module gcpm_pin_mux_tb;
  import gcpm_pkg::*;
  localparam int pd_cyc = 20;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, err, host_select_in, host_bus_spi, slew, cfreq, cprio, cact;
  logic [3:0] gpio_in, gpio_out, gpio_oe, gpio_pull_en, gpio_pull_up;
  logic wrst_pd, pmu_on, bext, bpwm;
  logic strap = 1'b1, peer_on = 1'b0, grant_src = 1'b0, irq_src = 1'b0;
  logic wrst_n = 1'b0, ssr = 1'b0, pwr = 1'b0;
  logic [2:0] peer_lvl = 3'b000;
  int n_mismatch = 0;
  int num_checks = 0;
  gcpm_pin_mux #(.pd_release_cycles(pd_cyc)) gcpm_pin_mux_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .host_select_in(host_select_in), .host_bus_spi(host_bus_spi), .gpio_in(gpio_in),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe), .gpio_pull_en(gpio_pull_en),
    .gpio_pull_up(gpio_pull_up), .slew_limit_en(slew), .coex_tx_grant_src(grant_src),
    .host_irq_src(irq_src), .coex_restricted_channel_in(cfreq),
    .coex_priority_direction_in(cprio), .coex_peer_active_in(cact),
    .wireless_reset_n(wrst_n), .wireless_reset_pd_en(wrst_pd), .power_manager_on(pmu_on),
    .supply_share_request(ssr), .buck_pwm_force_request(pwr),
    .core_buck_external(bext), .core_buck_pwm(bpwm));
  gcpm_peer_model gcpm_peer_model_inst (
    .pclk(pclk), .strap(strap), .peer_on(peer_on), .peer_lvl(peer_lvl),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe), .gpio_pull_en(gpio_pull_en),
    .gpio_pull_up(gpio_pull_up), .host_select_in(host_select_in), .gpio_in(gpio_in));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Ends on a falling edge so register-driven pins have settled
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk);
  endtask
  task automatic finish_test();
    if (n_mismatch == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    apb(1'b0, gcpm_mode_off, 32'h0000_0000);
    chk("mode", rd, 32'h0000_000E);
    apb(1'b0, gcpm_misc_off, 32'h0000_0000);
    chk("misc", rd, 32'h0000_0001);
    chk("oe", {gpio_pull_en, gpio_pull_up, gpio_oe}, 32'h0000_0000);
    chk("pmu", {pmu_on, wrst_pd}, 32'h0000_0001);
  endtask
  task automatic t_strap();
    @(posedge pclk);
    wrst_n <= 1'b1;
    repeat (4) @(negedge pclk);
    chk("spi", host_bus_spi, 32'h0000_0001);
    @(posedge pclk);
    strap <= 1'b0;
    repeat (3) @(negedge pclk);
    chk("spi", host_bus_spi, 32'h0000_0001);
  endtask
  task automatic t_pd();
    chk("pd", wrst_pd, 32'h0000_0001);
    repeat (pd_cyc) @(negedge pclk);
    chk("pd", wrst_pd, 32'h0000_0000);
    apb(1'b1, gcpm_misc_off, 32'h0000_0002);
    chk("pdsl", {wrst_pd, slew}, 32'h0000_0002);
    apb(1'b1, gcpm_misc_off, 32'h0000_0001);
    chk("pdsl", {wrst_pd, slew}, 32'h0000_0001);
  endtask
  task automatic t_gpio();
    apb(1'b1, gcpm_mode_off, 32'h0000_0000);
    apb(1'b1, gcpm_dir_off, 32'h0000_000F);
    apb(1'b1, gcpm_out_off, 32'hFFFF_FFFA);
    chk("drv", {gpio_oe, gpio_out}, 32'h0000_00FA);
    apb(1'b0, gcpm_pins_off, 32'h0000_0000);
    chk("pins", rd, 32'h0000_000A);
    apb(1'b0, gcpm_out_off, 32'h0000_0000);
    chk("out", rd, 32'h0000_000A);
    apb(1'b1, gcpm_pull_en_off, 32'h0000_0005);
    apb(1'b1, gcpm_pull_up_off, 32'h0000_0001);
    apb(1'b1, gcpm_dir_off, 32'h0000_0000);
    chk("pull", {gpio_oe, gpio_pull_en, gpio_pull_up}, 32'h0000_0051);
    apb(1'b0, gcpm_pins_off, 32'h0000_0000);
    chk("pins", rd & 32'h0000_0005, 32'h0000_0001);
    apb(1'b0, 12'h020, 32'h0000_0000);
    chk("err", err, 32'h0000_0001);
    apb(1'b1, gcpm_status_off, 32'h0000_0000);
    chk("err", err, 32'h0000_0001);
  endtask
  task automatic t_coex();
    apb(1'b1, gcpm_mode_off, 32'h0000_000F);
    @(posedge pclk);
    peer_on <= 1'b1;
    peer_lvl <= 3'b101;
    grant_src <= 1'b1;
    @(negedge pclk);
    chk("coex", {cact, cprio, cfreq}, 32'h0000_0005);
    chk("grant", {gpio_oe[1], gpio_out[1]}, 32'h0000_0003);
    @(posedge pclk);
    peer_lvl <= 3'b010;
    grant_src <= 1'b0;
    @(negedge pclk);
    chk("coex", {cact, cprio, cfreq, gpio_out[1]}, 32'h0000_0004);
    apb(1'b1, gcpm_mode_off, 32'h0000_0010);
    @(posedge pclk);
    irq_src <= 1'b1;
    @(negedge pclk);
    chk("irq", {gpio_oe[1], cprio, gpio_oe[0], gpio_out[0], cfreq}, 32'h0000_0006);
    @(posedge pclk);
    peer_on <= 1'b0;
    irq_src <= 1'b0;
    apb(1'b1, gcpm_misc_off, 32'h0000_000D);
    apb(1'b1, gcpm_mode_off, 32'h0000_0012);
    chk("soft", {gpio_oe[1], gpio_out[1], gpio_oe[0], gpio_out[0]}, 32'h0000_000F);
  endtask
  task automatic t_buck();
    @(posedge pclk);
    ssr <= 1'b1;
    @(negedge pclk);
    chk("buck", {pmu_on, bext, bpwm}, 32'h0000_0006);
    @(posedge pclk);
    ssr <= 1'b0;
    pwr <= 1'b1;
    @(negedge pclk);
    chk("buck", {bext, bpwm}, 32'h0000_0001);
    @(posedge pclk);
    wrst_n <= 1'b0;
    @(negedge pclk);
    chk("off", {pmu_on, wrst_pd, bpwm}, 32'h0000_0002);
    @(posedge pclk);
    wrst_n <= 1'b1;
    repeat (4) @(negedge pclk);
    chk("spi", {host_bus_spi, wrst_pd}, 32'h0000_0001);
  endtask
  // ----------------------------------------
  // Run
  // ----------------------------------------
  initial
  begin
    forever #20 pclk = ~pclk;
  end
  // The whole run needs about a hundred cycles
  initial
  begin
    repeat (3000) @(posedge pclk);
    n_mismatch++;
    finish_test();
  end
  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_strap();
    t_pd();
    t_gpio();
    t_coex();
    t_buck();
    finish_test();
  end
endmodule
